// ===== rtl/sbc_cycle_ctl.sv
// top: cycle decoder and control of a pipelined 32-bit burst cache sram
// assumes: bus pins are synchronous to mclk_in; sleep request is asynchronous;
// the memory core reads one cycle after its address and accepts queued writes
// What this block does
// - unselected strobe: deselect, no address, bus off
// - sleep request high: snooze, bus off
// - selected strobe without write begins read burst
// - controller strobe with write begins write burst
// - no strobe, advance low: read next address
// - no strobe, advance low, write: write next
// - no strobe, advance high: read current address
// - no strobe, advance high, write: write current
// - processor strobe start is always a read
// - writes only after start or controller start
// - output enable ignored in the cycle after a write cycle
// - output enable acts asynchronously on the bus
// - any write cycle turns the bus off
// - global write all bytes; gate high reads
// - two-bit wrap counter, linear or interleaved order
// - two cycles into and out of sleep
`timescale 1ns/1ns
module sbc_cycle_ctl (
    // clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         rst_b_in,
    // address and selects
    input  wire logic [sbc_pkg::ADDR_W-1:0]   addr_in,
    input  wire logic                         chip_select_first_b_in,
    input  wire logic                         chip_select_second_in,
    input  wire logic                         chip_select_third_b_in,
    // strobes and burst control
    input  wire logic                         processor_addr_strobe_b_in,
    input  wire logic                         controller_addr_strobe_b_in,
    input  wire logic                         burst_advance_b_in,
    input  wire logic                         burst_order_in,
    // write controls
    input  wire logic                         global_write_b_in,
    input  wire logic                         byte_write_gate_b_in,
    input  wire logic [sbc_pkg::LANES-1:0]    byte_lane_select_b_in,
    // asynchronous controls
    input  wire logic                         output_enable_b_in,
    input  wire logic                         sleep_request_in,
    // data bus
    input  wire logic [sbc_pkg::DATA_W-1:0]   dq_in,
    output logic      [sbc_pkg::DATA_W-1:0]   dq_out,
    output logic                              dq_oe_out,
    // memory core read port
    output logic                              core_rd_en_out,
    output logic      [sbc_pkg::ADDR_W-1:0]   core_rd_addr_out,
    input  wire logic [sbc_pkg::DATA_W-1:0]   core_rd_data_in,
    // memory core write port
    output logic                              core_wr_valid_out,
    output logic      [sbc_pkg::ADDR_W-1:0]   core_wr_addr_out,
    output logic      [sbc_pkg::LANES-1:0]    core_wr_lanes_out,
    output logic      [sbc_pkg::DATA_W-1:0]   core_wr_data_out,
    input  wire logic                         core_wr_ready_in,
    // status
    output logic                              snooze_out,
    output logic                              write_stall_out,
    output logic                              write_drop_out
);
    import sbc_pkg::*;

    // ==================================================================
    // state
    sbc_pwr_e            pwr_reg;
    sbc_pwr_e            pwr_next;
    logic [1:0]          pwr_cnt_reg;
    logic [1:0]          pwr_cnt_next;
    logic                zz_s1_reg;
    logic                zz_s2_reg;
    logic                zz_s3_reg;
    logic                sleep_lvl_reg;
    logic                burst_live_reg;
    logic [ADDR_W-1:0]   base_reg;
    logic [BURST_W-1:0]  first_reg;
    logic [BURST_W-1:0]  idx_reg;
    logic                rd_en_reg;
    logic [ADDR_W-1:0]   rd_addr_reg;
    logic                rd_pipe1_reg;
    logic                rd_pipe2_reg;
    logic [DATA_W-1:0]   dq_reg;
    logic                snooze_reg;
    logic                stall_reg;
    logic                drop_reg;
    logic [FIFO_W-1:0]   fifo_out_data;
    logic                fifo_in_ready;

    // ==================================================================
    // cycle decode
    wire                 awake     = (pwr_reg == SBC_ACTIVE);
    wire                 ce_all    = ~chip_select_first_b_in & chip_select_second_in
                                     & ~chip_select_third_b_in;
    wire                 p_seen    = ~chip_select_first_b_in & ~processor_addr_strobe_b_in;
    wire                 c_seen    = ~controller_addr_strobe_b_in & ~p_seen;
    wire [LANES-1:0]     lanes     = sbc_lanes(global_write_b_in, byte_write_gate_b_in,
                                               byte_lane_select_b_in);
    wire                 wr_req    = |lanes;
    wire                 start_p   = awake & p_seen & ce_all;
    wire                 start_c   = awake & c_seen & ce_all;
    wire                 start     = start_p | start_c;
    wire                 desel     = awake & (p_seen | c_seen) & ~ce_all;
    wire                 cont      = awake & ~p_seen & controller_addr_strobe_b_in
                                     & burst_live_reg;
    wire                 write_cyc = (start_c | cont) & wr_req;
    wire                 read_cyc  = start_p | ((start_c | cont) & ~wr_req);

    // ==================================================================
    // burst address
    // wrap counter select
    wire [BURST_W-1:0]   idx_use   = start ? BURST_IDX_RST :
                                     (burst_advance_b_in ? idx_reg : idx_reg + 2'h1);
    wire [BURST_W-1:0]   first_use = start ? addr_in[BURST_W-1:0] : first_reg;
    wire [ADDR_W-1:0]    base_use  = start ? addr_in : base_reg;
    wire [BURST_W-1:0]   low_use   = sbc_burst(burst_order_in, first_use, idx_use);
    wire [ADDR_W-1:0]    acc_addr  = {base_use[ADDR_W-1:BURST_W], low_use};
    wire [FIFO_W-1:0]    entry     = {acc_addr, lanes, dq_in};

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            base_reg       <= ADDR_RST;
            first_reg      <= BURST_IDX_RST;
            idx_reg        <= BURST_IDX_RST;
            burst_live_reg <= 1'b0;
        end else begin
            if (start | cont) begin
                base_reg  <= base_use;
                first_reg <= first_use;
                idx_reg   <= idx_use;
            end
            if (start) begin
                burst_live_reg <= 1'b1;
            end else if (desel | ~awake) begin
                burst_live_reg <= 1'b0;
            end
        end
    end

    // ==================================================================
    // read path
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_en_reg    <= 1'b0;
            rd_addr_reg  <= ADDR_RST;
            rd_pipe1_reg <= 1'b0;
            rd_pipe2_reg <= 1'b0;
            dq_reg       <= DATA_RST;
        end else begin
            rd_en_reg    <= read_cyc;
            rd_pipe1_reg <= read_cyc;
            if (read_cyc) begin
                rd_addr_reg <= acc_addr;
            end
            rd_pipe2_reg <= rd_pipe1_reg & ~write_cyc & ~desel & awake;
            if (rd_pipe1_reg) begin
                dq_reg <= core_rd_data_in;
            end
        end
    end

    assign dq_oe_out        = rd_pipe2_reg & ~output_enable_b_in & ~sleep_request_in
                              & ~snooze_reg;
    assign dq_out           = dq_reg;
    assign core_rd_en_out   = rd_en_reg;
    assign core_rd_addr_out = rd_addr_reg;

    // ==================================================================
    // write path
    // capture bus data
    sbc_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) sbc_fifo_i (
        .clk_in        (mclk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (write_cyc),
        .in_data_in    (entry),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (core_wr_valid_out),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (core_wr_ready_in)
    );

    assign core_wr_addr_out  = fifo_out_data[ENT_ADDR_LSB +: ADDR_W];
    assign core_wr_lanes_out = fifo_out_data[ENT_LANES_LSB +: LANES];
    assign core_wr_data_out  = fifo_out_data[ENT_DATA_LSB +: DATA_W];

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stall_reg <= 1'b0;
            drop_reg  <= 1'b0;
        end else begin
            stall_reg <= ~fifo_in_ready;
            drop_reg  <= write_cyc & ~fifo_in_ready;
        end
    end

    assign write_stall_out = stall_reg;
    assign write_drop_out  = drop_reg;

    // ==================================================================
    // sleep control
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            zz_s1_reg     <= 1'b0;
            zz_s2_reg     <= 1'b0;
            zz_s3_reg     <= 1'b0;
            sleep_lvl_reg <= 1'b0;
        end else begin
            zz_s1_reg <= sleep_request_in;
            zz_s2_reg <= zz_s1_reg;
            zz_s3_reg <= zz_s2_reg;
            if (zz_s2_reg == zz_s3_reg) begin
                sleep_lvl_reg <= zz_s3_reg;
            end
        end
    end

    wire cnt_done = (pwr_cnt_reg == 2'(SLEEP_CYC - 1));

    always_comb begin
        pwr_next     = pwr_reg;
        pwr_cnt_next = SLEEP_CNT_RST;
        case (pwr_reg)
            SBC_ACTIVE: begin
                if (sleep_lvl_reg) begin
                    pwr_next = SBC_ENTER;
                end
            end
            SBC_ENTER: begin
                pwr_cnt_next = pwr_cnt_reg + 2'h1;
                if (!sleep_lvl_reg) begin
                    pwr_next     = SBC_WAKE;
                    pwr_cnt_next = SLEEP_CNT_RST;
                end else if (cnt_done) begin
                    pwr_next     = SBC_SNOOZE;
                    pwr_cnt_next = SLEEP_CNT_RST;
                end
            end
            SBC_SNOOZE: begin
                if (!sleep_lvl_reg) begin
                    pwr_next = SBC_WAKE;
                end
            end
            SBC_WAKE: begin
                pwr_cnt_next = pwr_cnt_reg + 2'h1;
                if (sleep_lvl_reg) begin
                    pwr_next     = SBC_ENTER;
                    pwr_cnt_next = SLEEP_CNT_RST;
                end else if (cnt_done) begin
                    pwr_next     = SBC_ACTIVE;
                    pwr_cnt_next = SLEEP_CNT_RST;
                end
            end
            default: begin
                pwr_next = SBC_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pwr_reg     <= SBC_ACTIVE;
            pwr_cnt_reg <= SLEEP_CNT_RST;
            snooze_reg  <= 1'b0;
        end else begin
            pwr_reg     <= pwr_next;
            pwr_cnt_reg <= pwr_cnt_next;
            snooze_reg  <= (pwr_next == SBC_SNOOZE);
        end
    end

    assign snooze_out = snooze_reg;

    // ==================================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    AST_DESEL_QUIET: assert property (desel |=> !dq_oe_out)
        else $error("bus driven after deselect");
    AST_SLEEP_QUIET: assert property (sleep_request_in |-> !dq_oe_out)
        else $error("bus driven during sleep request");
    AST_PSTART_READ: assert property (start_p |=> core_rd_en_out
        && core_rd_addr_out == $past(addr_in))
        else $error("processor start did not read presented address");
    AST_CSTART_WRITE: assert property (start_c && wr_req && fifo_in_ready
        |=> $changed(sbc_fifo_i.count_reg) || core_wr_valid_out)
        else $error("controller write start not queued");
    AST_NEXT_ADDR: assert property (cont && !burst_advance_b_in && !wr_req
        |=> core_rd_addr_out[1:0] == sbc_burst($past(burst_order_in), $past(first_reg),
                                             $past(idx_reg) + 2'h1))
        else $error("continue read used wrong burst address");
    AST_HOLD_ADDR: assert property (cont && burst_advance_b_in
        |=> $stable(idx_reg) && $stable(first_reg))
        else $error("suspended burst moved its address");
    AST_PSTART_NO_WRITE: assert property (start_p |-> !write_cyc)
        else $error("processor start produced a write");
    AST_NO_LOOSE_WRITE: assert property (!burst_live_reg && !start_c |-> !write_cyc)
        else $error("write outside a burst");
    AST_WRITE_QUIET: assert property (write_cyc |=> !dq_oe_out [*1] ##1 1)
        else $error("bus driven after write detected");
    AST_OE_ASYNC: assert property (output_enable_b_in |-> !dq_oe_out)
        else $error("bus driven with output enable off");
    AST_GLOBAL_ALL: assert property (!global_write_b_in |-> lanes == LANES_ALL)
        else $error("global write not all lanes");
    AST_SLEEP_ENTRY: assert property ($rose(snooze_out)
        |-> $past(pwr_reg, 1) == SBC_ENTER && $past(pwr_reg, 2) == SBC_ENTER)
        else $error("sleep entered without two cycle entry");
    AST_SLEEP_EXIT: assert property ($fell(snooze_out) |-> !awake ##1 !awake)
        else $error("sleep left in fewer than two cycles");
    AST_ASLEEP_NO_READ: assert property (!awake |=> !core_rd_en_out)
        else $error("read issued outside the active state");
    AST_WRITE_ADVANCE: assert property (cont && !burst_advance_b_in && wr_req
        |=> idx_reg == $past(idx_reg) + 2'h1)
        else $error("continue write did not advance burst address");
    AST_WRITE_HOLD: assert property (cont && burst_advance_b_in && wr_req
        |=> $stable(idx_reg))
        else $error("suspended write moved burst address");
    AST_GATE_READ: assert property (global_write_b_in && byte_write_gate_b_in
        |-> !wr_req)
        else $error("write decoded with byte write gate high");
    AST_LANE_EACH: assert property (global_write_b_in && !byte_write_gate_b_in
        |-> lanes == ~byte_lane_select_b_in)
        else $error("byte lane decode wrong");

    COV_READ_BURST: cover property (start_p ##1 cont && !burst_advance_b_in);
    COV_WRITE_BURST: cover property (start_c && wr_req ##1 cont && wr_req);
    COV_SUSPEND: cover property (cont && burst_advance_b_in);
    COV_SNOOZE: cover property ($rose(snooze_out) ##[1:20] pwr_reg == SBC_ACTIVE);

endmodule

// ===== rtl/sbc_fifo.sv
// write fifo: queues captured write entries toward the memory core
// assumes: one clock, drain side may stall; read data come out of a register
`timescale 1ns/1ns
module sbc_fifo #(
    parameter int W     = sbc_pkg::FIFO_W,
    parameter int DEPTH = sbc_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    // fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // drain side
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic [AW:0]   count_next;
    logic          out_valid_reg;
    logic [W-1:0]  out_data_reg;
    wire           push;
    wire           load;

    // ==================================================================
    // handshakes
    assign in_ready_out  = (count_reg != FULL_CNT);
    assign push          = in_valid_in & in_ready_out;
    assign load          = (count_reg != '0) & (~out_valid_reg | out_ready_in);
    assign count_next    = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    assign out_valid_out = out_valid_reg;
    assign out_data_out  = out_data_reg;

    // ==================================================================
    // storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(load);
            count_reg  <= count_next;
            if (load) begin
                out_data_reg <= mem[rd_ptr_reg];
            end
            if (load) begin
                out_valid_reg <= 1'b1;
            end else if (out_ready_in) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

endmodule

// ===== rtl/sbc_pkg.sv
// package: widths, depths, reset values and decode helpers of the burst cycle control
// assumes: included first in compile order, shared by the top and the write fifo
package sbc_pkg;

    // ==================================================================
    // widths and depths
    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 32;
    localparam int LANES      = 4;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = ADDR_W + LANES + DATA_W;

    // ==================================================================
    // field positions of a write fifo entry
    localparam int ENT_DATA_LSB  = 0;
    localparam int ENT_LANES_LSB = DATA_W;
    localparam int ENT_ADDR_LSB  = DATA_W + LANES;

    // ==================================================================
    // cycle counts and reset values
    localparam int                 SLEEP_CYC     = 2;
    localparam logic [1:0]         SLEEP_CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_IDX_RST = 2'h0;
    localparam logic [ADDR_W-1:0]  ADDR_RST      = 17'h00000;
    localparam logic [DATA_W-1:0]  DATA_RST      = 32'h00000000;
    localparam logic [LANES-1:0]   LANES_NONE    = 4'h0;
    localparam logic [LANES-1:0]   LANES_ALL     = 4'hf;

    // ==================================================================
    // power states
    typedef enum logic [1:0] {
        SBC_ACTIVE,
        SBC_ENTER,
        SBC_SNOOZE,
        SBC_WAKE
    } sbc_pwr_e;

    // ==================================================================
    // byte lanes to write, from the active-low write controls
    function automatic logic [LANES-1:0] sbc_lanes(input logic gw_b,
                                                   input logic gate_b,
                                                   input logic [LANES-1:0] sel_b);
        logic [LANES-1:0] l;
        l = LANES_NONE;
        if (!gw_b) begin
            l = LANES_ALL;
        end else if (!gate_b) begin
            l = ~sel_b;
        end
        return l;
    endfunction

    // burst address low bits: linear adds, interleaved xors
    function automatic logic [BURST_W-1:0] sbc_burst(input logic interleave,
                                                     input logic [BURST_W-1:0] first,
                                                     input logic [BURST_W-1:0] idx);
        logic [BURST_W-1:0] r;
        r = first + idx;
        if (interleave) begin
            r = first ^ idx;
        end
        return r;
    endfunction

endpackage

// ===== sim/sbc_core_model.sv
// memory core model: 64-word store behind the core read and write ports
// assumes: read data follows the held read address, writes merge byte lanes
`timescale 1ns/1ns
module sbc_core_model (
    input  wire logic        clk_in,
    input  wire logic        stall_in,
    input  wire logic [16:0] rd_addr_in,
    output logic      [31:0] rd_data_out,
    input  wire logic        wr_valid_in,
    input  wire logic [16:0] wr_addr_in,
    input  wire logic [3:0]  wr_lanes_in,
    input  wire logic [31:0] wr_data_in,
    output logic             wr_ready_out
);
    logic [31:0] mem [0:63];
    logic [31:0] wmask;
    int          sd = 32;
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 32'h0;
        end
    end
    assign rd_data_out = mem[rd_addr_in[5:0]];
    assign wmask = {{8{wr_lanes_in[3]}}, {8{wr_lanes_in[2]}}, {8{wr_lanes_in[1]}},
                    {8{wr_lanes_in[0]}}};
    // accept writes with random stalls, none after the first edge that sees stall_in high
    always @(posedge clk_in) begin
        if (wr_valid_in && wr_ready_out) begin
            mem[wr_addr_in[5:0]] <= (mem[wr_addr_in[5:0]] & ~wmask) | (wr_data_in & wmask);
        end
        wr_ready_out <= !stall_in && ($random(sd) % 3 != 0);
    end
endmodule

// ===== sim/sbc_cycle_ctl_tb.sv
// bench: random and corner bus cycles through the burst cycle control
// assumes: core model on the core ports, inputs driven 1 ns after the rising edge
`timescale 1ns/1ns
module sbc_cycle_ctl_tb;
    import sbc_pkg::*;
    // ==========================================
    // signals
    logic              clk = 1'b0, rst_b = 1'b0, live = 1'b0, r1 = 1'b0;
    logic [7:0]        v = 8'h9f;
    logic              cs1_b, cs2, cs3_b, ps_b, cc_b, adv_b, gw_b, gate_b;
    logic [ADDR_W-1:0] addr = '0, base = '0, rd_addr, wa;
    logic [LANES-1:0]  lsel_b = 4'hf, wl;
    logic              ord = 1'b0, oe_b = 1'b0, zz = 1'b0, stall = 1'b0;
    logic [DATA_W-1:0] dq_i = '0, dq_o, rd_data, wd, e1;
    logic              dq_oe, rd_en, wv, wr_rdy, snz, full, drop;
    logic [31:0]       shadow [0:63];
    logic [1:0]        idx = 2'h0;
    int                seed = 32, err_total = 0, samples_checked = 0, cyc = 0, drops = 0;
    assign {cs1_b, cs2, cs3_b, ps_b, cc_b, adv_b, gw_b, gate_b} = v;
    sbc_cycle_ctl sbc_cycle_ctl_i (.mclk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
        .chip_select_first_b_in(cs1_b), .chip_select_second_in(cs2),
        .chip_select_third_b_in(cs3_b), .processor_addr_strobe_b_in(ps_b),
        .controller_addr_strobe_b_in(cc_b), .burst_advance_b_in(adv_b),
        .burst_order_in(ord), .global_write_b_in(gw_b), .byte_write_gate_b_in(gate_b),
        .byte_lane_select_b_in(lsel_b), .output_enable_b_in(oe_b),
        .sleep_request_in(zz), .dq_in(dq_i), .dq_out(dq_o), .dq_oe_out(dq_oe),
        .core_rd_en_out(rd_en), .core_rd_addr_out(rd_addr), .core_rd_data_in(rd_data),
        .core_wr_valid_out(wv), .core_wr_addr_out(wa), .core_wr_lanes_out(wl),
        .core_wr_data_out(wd), .core_wr_ready_in(wr_rdy), .snooze_out(snz),
        .write_stall_out(full), .write_drop_out(drop));
    sbc_core_model sbc_core_model_i (.clk_in(clk), .stall_in(stall), .rd_addr_in(rd_addr),
        .rd_data_out(rd_data), .wr_valid_in(wv), .wr_addr_in(wa), .wr_lanes_in(wl),
        .wr_data_in(wd), .wr_ready_out(wr_rdy));
    initial begin
        forever #5 clk = ~clk;
    end
    // ==========================================
    // expectations and checks
    function automatic logic [31:0] mrg(input logic [31:0] o, d, input logic [3:0] l);
        logic [31:0] m;
        m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
        return (o & ~m) | (d & m);
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one bus cycle: decode the cycle, clock it, check the read due two edges back
    task automatic tick();
        logic p, c, wr, rd;
        logic [3:0] l;
        logic [16:0] a;
        p = !cs1_b && !ps_b;
        c = !cc_b && !p;
        l = !gw_b ? 4'hf : (!gate_b ? ~lsel_b : 4'h0);
        wr = 1'b0;
        rd = 1'b0;
        if (snz === 1'b1 || ((p || c) && !(!cs1_b && cs2 && !cs3_b))) begin
            live = 1'b0;
            r1 = 1'b0;
        end else if (p || c || live) begin
            if (p || c) begin
                base = addr;
                idx = 2'h0;
            end else if (!adv_b) begin
                idx = idx + 2'h1;
            end
            wr = !p && l != 4'h0;
            rd = !wr;
            live = 1'b1;
        end
        a = {base[16:2], ord ? base[1:0] ^ idx : base[1:0] + idx};
        oe_b = wr;
        if (wr) begin
            shadow[a[5:0]] = mrg(shadow[a[5:0]], dq_i, l);
            r1 = 1'b0;
        end
        @(posedge clk);
        #1;
        if (drop === 1'b1) drops++;
        chk(dq_oe, r1 && !oe_b);
        if (r1) chk(dq_o, e1);
        chk(rd_en, rd);
        if (rd) chk(rd_addr, a);
        r1 = rd;
        e1 = shadow[a[5:0]];
    endtask
    task automatic drain();
        int n, q;
        n = 0;
        q = 0;
        v = 8'h17;
        tick();
        v = 8'h9f;
        while (q < 3 && n < 80) begin
            tick();
            q = wv === 1'b0 ? q + 1 : 0;
            n++;
        end
        chk(q, 3);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    // ==========================================
    // scenarios
    initial begin
        int n;
        for (int i = 0; i < 64; i++) shadow[i] = 32'h0;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk(dq_oe, 1'b0);
        for (int i = 0; i < 18; i++) begin
            addr = 17'(i);
            lsel_b = i[3:0];
            dq_i = $random(seed);
            v = i == 16 ? 8'h55 : (i == 17 ? 8'h57 : 8'h56);
            tick();
        end
        drain();
        for (int i = 0; i < 18; i++) begin
            addr = 17'(i);
            v = 8'h4c;
            tick();
        end
        for (int o = 0; o < 2; o++) begin
            ord = o[0];
            addr = 17'($random(seed) & 32'h3f);
            v = 8'h4c;
            tick();
            v = 8'h8b;
            repeat (3) tick();
            v = 8'h9f;
            tick();
            v = 8'h8b;
            tick();
            v = 8'h6f;
            tick();
            v = 8'h9f;
            repeat (3) tick();
        end
        addr = 17'($random(seed) & 32'h3c);
        lsel_b = 4'h0;
        for (int i = 0; i < 4; i++) begin
            dq_i = $random(seed);
            v = i == 0 ? 8'h4c : (i == 1 ? 8'h99 : (i == 2 ? 8'h56 : 8'h9d));
            tick();
            oe_b = 1'b0;
            #1;
            chk(dq_oe, 1'b0);
        end
        drain();
        v = 8'h4c;
        tick();
        v = 8'h8b;
        repeat (2) tick();
        oe_b = 1'b1;
        #1;
        chk(dq_oe, 1'b0);
        zz = 1'b1;
        oe_b = 1'b0;
        #1;
        chk(dq_oe, 1'b0);
        zz = 1'b0;
        drain();
        zz = 1'b1;
        for (n = 0; n < 12 && snz !== 1'b1; n++) tick();
        chk(snz, 1'b1);
        chk(n >= 2, 1'b1);
        v = 8'h4c;
        tick();
        v = 8'h9f;
        repeat (2) tick();
        zz = 1'b0;
        for (n = 0; n < 12 && snz !== 1'b0; n++) tick();
        chk(snz, 1'b0);
        repeat (3) tick();
        stall = 1'b1;
        repeat (2) tick();
        addr = 17'h28;
        dq_i = $random(seed);
        drops = 0;
        v = 8'h55;
        repeat (20) tick();
        v = 8'h17;
        repeat (2) tick();
        chk(full, 1'b1);
        chk(drops, 3);
        stall = 1'b0;
        drain();
        chk(full, 1'b0);
        v = 8'h4c;
        tick();
        v = 8'h9f;
        tick();
        drain();
        print_verdict();
    end
endmodule
